// *** verilog/ref_clk_regs.vh ***
// Register map, field positions, reset values and counts for the reference clock block.
//
// Operation
// RULE1 - Pre-divide zero powers down PLLs zero to two.
// RULE2 - Software keeps fourth PLL pre-divide at 3 or more.
// RULE3 - First PLL M is 2N+A+1, else 2N.
// RULE4 - Seven-bit pre-divide, twelve-bit feedback per PLL.
// RULE5 - Output frequency is input times M/D/divide.
// RULE6 - Source select bit picks which input is primary.
// RULE7 - Mode field upper bit zero means manual.
// RULE8 - Manual mode: select pin picks primary or secondary.
// RULE9 - Manual switchover produces no output glitches.
// RULE10 - Auto: secondary after two idle secondary cycles.
// RULE11 - Auto mode reverts to primary once it returns.
// RULE12 - Software uses auto only with crystal input primary.
// RULE13 - Software avoids switchover with a crystal fitted.
// RULE14 - Switching is asynchronous; routed references may pulse. The design swaps on clk, only while output and new source are low.
// RULE15 - Secondary never runs faster than the primary.
// RULE16 - Load capacitance is 3.5 pF plus trim eighths.
// RULE17 - External reference: trim 00h, drive at default.
// RULE18 - Output divider decode of count and mode bit.
// RULE19 - Disabled output idles at chosen level, stays powered.
// RULE20 - Output zero has no divider; others even 2-256.
// RULE21 - Software disables dividers only on unused banks.
// RULE22 - Monitor counts secondary edges since last primary edge.
`ifndef REF_CLK_REGS_VH
`define REF_CLK_REGS_VH

`define CFG_ADDR       8'h00
`define CRYSTAL_LOAD_TRIM_ADDR      8'h01
`define STAT_ADDR      8'h02
`define PLL_D_BASE     8'h10
`define PLL_N_BASE     8'h14
`define PLL0_A_ADDR    8'h18
`define OUT_BASE       8'h21
`define PLL_M_BASE     8'h30
`define OUT_RATIO_BASE 8'h41

`define CFG_PRIM_BIT   0
`define CFG_MODE_LO    1
`define CFG_MODE_HI    2
`define CRYSTAL_LOAD_TRIM_TRIM_HI   4
`define CRYSTAL_LOAD_TRIM_DRV_LO    8
`define CRYSTAL_LOAD_TRIM_DRV_HI    9
`define OUT_Q_HI       6
`define OUT_PM_BIT     7
`define OUT_OEM_LO     8
`define OUT_OEM_HI     9

`define CFG_RST        3'h0
`define CRYSTAL_LOAD_TRIM_TRIM_RST  5'h00
`define CRYSTAL_LOAD_TRIM_DRV_RST   2'h3
`define PLL_D_RST      7'h01
`define PLL3_D_RST     7'h03
`define PLL3_D_MIN     7'h03
`define PLL_N_RST      12'h005
`define PLL0_A_RST     4'h0
`define OUT_Q_RST      7'h7F
`define OUT_Q_ALL      7'h7F
`define OUT_PM_RST     1'b1
`define OUT_OEM_RST    2'h0

`define LOSS_EDGES     2'h2
`define LOAD_BASE_8THS 6'h1C

`endif

// *** verilog/sync2.v ***
// Two-flop synchroniser for asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst,
   // Levels
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);
   reg [W-1:0] meta_q;

   always @(posedge clk) begin
      if (rst) begin
         meta_q   <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // sync2
`default_nettype wire

// *** verilog/out_div_decode.v ***
// Decoder of one output bank divider setting into a ratio and idle state.
`timescale 1ns/1ps
`default_nettype none
`include "ref_clk_regs.vh"
module out_div_decode (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Setting
   input  wire [6:0] div_count,
   input  wire       divider_mode_bit,
   input  wire [1:0] idle_output_level,
   // Decoded
   output reg  [8:0] ratio_q,
   output reg        enable_q,
   output reg  [1:0] idle_q
);
   // The sum is widened first so that a count of 7Eh still gives a ratio of 256.
   wire [8:0] count_ratio = {{1'b0, div_count} + 8'h02, 1'b0};

   always @(posedge clk) begin
      if (rst) begin
         ratio_q  <= 9'h001;
         enable_q <= 1'b1;
         idle_q   <= `OUT_OEM_RST;
      end else begin
         if (div_count == `OUT_Q_ALL) begin
            ratio_q  <= divider_mode_bit ? 9'h001 : 9'h000; // RULE18
            enable_q <= divider_mode_bit; // RULE18
         end else begin
            ratio_q  <= divider_mode_bit ? count_ratio : 9'h002; // RULE20
            enable_q <= 1'b1;
         end
         // Divider stays powered; only the pin level is chosen when idle.
         idle_q <= idle_output_level; // RULE19
      end
   end
endmodule // out_div_decode
`default_nettype wire

// *** verilog/ref_clock_select_and_dividers.v ***
// Reference clock selection, loss monitor and PLL/output divider configuration.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ref_clk_regs.vh"
module ref_clock_select_and_dividers #(
   parameter NPLL = 4,
   parameter NOUT = 6
) (
   // Clock and reset
   input  wire               clk,
   input  wire               rst,
   // Register port
   input  wire [7:0]         addr,
   input  wire [15:0]        wdata,
   input  wire               wr,
   input  wire               rd,
   output reg  [15:0]        rdata,
   // Reference pins
   input  wire               crystal_ref_input,
   input  wire               alt_clock_input,
   input  wire               input_select_pin,
   // Reference selection
   output reg                ref_clk_out,
   output reg                on_secondary,
   output reg                primary_lost,
   // PLL settings
   output reg  [NPLL-1:0]    pll_power_down,
   output reg  [NPLL*7-1:0]  pll_pre_divide,
   output reg  [NPLL*14-1:0] pll_feedback_m,
   // Output banks one and up
   output wire [NOUT*9-1:0]  out_ratio,
   output wire [NOUT-1:0]    out_enable,
   output wire [NOUT*2-1:0]  out_idle_level,
   // Crystal oscillator
   output reg  [5:0]         crystal_load_cap,
   output reg  [1:0]         crystal_drive_strength
);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers.

   reg               primary_source_select_q;
   reg  [1:0]        switchover_select_q;
   reg  [4:0]        crystal_load_trim_q;
   reg  [1:0]        drive_q;
   reg  [NPLL*7-1:0] pre_div_q;
   reg  [NPLL*12-1:0] fb_div_q;
   reg  [3:0]        pll0_a_q;
   reg  [NOUT*7-1:0] out_count_q;
   reg  [NOUT-1:0]   out_mode_q;
   reg  [NOUT*2-1:0] out_oem_q;
   integer           i;

   always @(posedge clk) begin
      if (rst) begin
         primary_source_select_q <= 1'b0;
         switchover_select_q     <= 2'h0;
         crystal_load_trim_q     <= `CRYSTAL_LOAD_TRIM_TRIM_RST;
         drive_q                 <= `CRYSTAL_LOAD_TRIM_DRV_RST;
         pll0_a_q                <= `PLL0_A_RST;
         for (i = 0; i < NPLL; i = i + 1) begin
            pre_div_q[i*7 +: 7]  <= (i == 3) ? `PLL3_D_RST : `PLL_D_RST;
            fb_div_q[i*12 +: 12] <= `PLL_N_RST;
         end
         for (i = 0; i < NOUT; i = i + 1) begin
            out_count_q[i*7 +: 7] <= `OUT_Q_RST;
            out_mode_q[i]         <= `OUT_PM_RST;
            out_oem_q[i*2 +: 2]   <= `OUT_OEM_RST;
         end
      end else if (wr) begin
         if (addr == `CFG_ADDR) begin
            primary_source_select_q <= wdata[`CFG_PRIM_BIT];
            switchover_select_q     <= wdata[`CFG_MODE_HI:`CFG_MODE_LO];
         end
         if (addr == `CRYSTAL_LOAD_TRIM_ADDR) begin
            crystal_load_trim_q <= wdata[`CRYSTAL_LOAD_TRIM_TRIM_HI:0];
            drive_q             <= wdata[`CRYSTAL_LOAD_TRIM_DRV_HI:`CRYSTAL_LOAD_TRIM_DRV_LO];
         end
         if (addr == `PLL0_A_ADDR)
            pll0_a_q <= wdata[3:0];
         for (i = 0; i < NPLL; i = i + 1) begin
            if (addr == `PLL_D_BASE + i[7:0])
               pre_div_q[i*7 +: 7] <= wdata[6:0]; // RULE4
            if (addr == `PLL_N_BASE + i[7:0])
               fb_div_q[i*12 +: 12] <= wdata[11:0]; // RULE4
         end
         for (i = 0; i < NOUT; i = i + 1) begin
            if (addr == `OUT_BASE + i[7:0]) begin
               out_count_q[i*7 +: 7] <= wdata[`OUT_Q_HI:0];
               out_mode_q[i]         <= wdata[`OUT_PM_BIT];
               out_oem_q[i*2 +: 2]   <= wdata[`OUT_OEM_HI:`OUT_OEM_LO];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference synchronisers and edge detection.

   wire [2:0] pin_s;
   reg  [1:0] pin_last_q;

   sync2 #(
      .W (3)
   ) u_pin_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({input_select_pin, alt_clock_input, crystal_ref_input}),
      .sync_out (pin_s)
   );

   // Primary and secondary swap with the source select bit.
   wire prim_lvl  = primary_source_select_q ? pin_s[1] : pin_s[0]; // RULE6
   wire sec_lvl   = primary_source_select_q ? pin_s[0] : pin_s[1]; // RULE6
   wire prim_last = primary_source_select_q ? pin_last_q[1] : pin_last_q[0];
   wire sec_last  = primary_source_select_q ? pin_last_q[0] : pin_last_q[1];
   wire prim_edge = prim_lvl != prim_last;
   wire sec_rise  = sec_lvl & ~sec_last;

   always @(posedge clk) begin
      if (rst)
         pin_last_q <= 2'h0;
      else
         pin_last_q <= pin_s[1:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Loss-of-transition monitor and selection.

   reg  [1:0] sec_count_q;
   wire       lost      = sec_count_q == `LOSS_EDGES;
   wire       auto_mode = switchover_select_q[1]; // RULE7
   reg        want_sec;

   always @(posedge clk) begin
      if (rst)
         sec_count_q <= 2'h0;
      else if (prim_edge)
         sec_count_q <= 2'h0; // RULE22
      else if (sec_rise && !lost)
         sec_count_q <= sec_count_q + 2'h1; // RULE22
   end

   always @* begin
      if (auto_mode)
         want_sec = lost & ~prim_edge; // RULE10 RULE11
      else
         want_sec = pin_s[2]; // RULE8
   end

   // The mux only moves while the output and the incoming source are both
   // low, so no runt pulse reaches the PLL reference.
   wire new_lvl   = want_sec ? sec_lvl : prim_lvl;
   wire swap_safe = ~ref_clk_out & ~new_lvl; // RULE9

   always @(posedge clk) begin
      if (rst) begin
         on_secondary <= 1'b0;
         ref_clk_out  <= 1'b0;
         primary_lost <= 1'b0;
      end else begin
         primary_lost <= lost;
         if (want_sec != on_secondary && swap_safe) begin
            on_secondary <= want_sec; // RULE14
            ref_clk_out  <= new_lvl;
         end else begin
            ref_clk_out <= on_secondary ? sec_lvl : prim_lvl;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PLL divider decode.

   genvar p;
   generate
      for (p = 0; p < NPLL; p = p + 1) begin : g_pll
         wire [6:0]  d = pre_div_q[p*7 +: 7];
         wire [11:0] n = fb_div_q[p*12 +: 12];
         wire [13:0] m;
         if (p == 0) begin : g_frac
            assign m = (pll0_a_q == 4'h0) ? {1'b0, n, 1'b0} :
                       ({1'b0, n, 1'b0} + {10'h000, pll0_a_q} + 14'h0001); // RULE3
         end else begin : g_int
            assign m = {2'h0, n}; // RULE3
         end
         always @(posedge clk) begin
            if (rst) begin
               pll_power_down[p]         <= 1'b0;
               pll_pre_divide[p*7 +: 7]  <= 7'h00;
               pll_feedback_m[p*14 +: 14] <= 14'h0000;
            end else begin
               pll_power_down[p]         <= (p < 3) && (d == 7'h00); // RULE1
               pll_pre_divide[p*7 +: 7]  <= d; // RULE5
               pll_feedback_m[p*14 +: 14] <= m; // RULE5
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Output bank dividers.

   genvar b;
   generate
      for (b = 0; b < NOUT; b = b + 1) begin : g_out
         out_div_decode u_dec (
            .clk               (clk),
            .rst               (rst),
            .div_count         (out_count_q[b*7 +: 7]),
            .divider_mode_bit  (out_mode_q[b]),
            .idle_output_level (out_oem_q[b*2 +: 2]),
            .ratio_q           (out_ratio[b*9 +: 9]),
            .enable_q          (out_enable[b]),
            .idle_q            (out_idle_level[b*2 +: 2])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Crystal oscillator settings.

   always @(posedge clk) begin
      if (rst) begin
         crystal_load_cap       <= `LOAD_BASE_8THS;
         crystal_drive_strength <= `CRYSTAL_LOAD_TRIM_DRV_RST;
      end else begin
         crystal_load_cap       <= `LOAD_BASE_8THS + {1'b0, crystal_load_trim_q}; // RULE16
         crystal_drive_strength <= drive_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port.

   // Flags settings the system must avoid: bad fourth pre-divide, or
   // automatic mode with the alternate input as primary.
   wire cfg_warn = (pre_div_q[3*7 +: 7] < `PLL3_D_MIN) // RULE2
                 | (auto_mode & primary_source_select_q); // RULE12
   reg [15:0] rd_mux;

   always @* begin
      rd_mux = 16'h0000;
      if (addr == `CFG_ADDR)
         rd_mux = {13'h0000, switchover_select_q, primary_source_select_q};
      if (addr == `CRYSTAL_LOAD_TRIM_ADDR)
         rd_mux = {6'h00, drive_q, 3'h0, crystal_load_trim_q};
      if (addr == `STAT_ADDR)
         rd_mux = {12'h000, cfg_warn, ~auto_mode, primary_lost, on_secondary};
      if (addr == `PLL0_A_ADDR)
         rd_mux = {12'h000, pll0_a_q};
      for (i = 0; i < NPLL; i = i + 1) begin
         if (addr == `PLL_D_BASE + i[7:0])
            rd_mux = {9'h000, pre_div_q[i*7 +: 7]};
         if (addr == `PLL_N_BASE + i[7:0])
            rd_mux = {4'h0, fb_div_q[i*12 +: 12]};
         if (addr == `PLL_M_BASE + i[7:0])
            rd_mux = {2'h0, pll_feedback_m[i*14 +: 14]};
      end
      for (i = 0; i < NOUT; i = i + 1) begin
         if (addr == `OUT_BASE + i[7:0])
            rd_mux = {6'h00, out_oem_q[i*2 +: 2], out_mode_q[i], out_count_q[i*7 +: 7]};
         if (addr == `OUT_RATIO_BASE + i[7:0])
            rd_mux = {7'h00, out_ratio[i*9 +: 9]};
      end
   end

   always @(posedge clk) begin
      if (rst)
         rdata <= 16'h0000;
      else if (rd)
         rdata <= rd_mux;
      else
         rdata <= 16'h0000;
   end

endmodule // ref_clock_select_and_dividers
`default_nettype wire

// *** tb/ref_src_model.sv ***
// Two reference clock sources that the bench can stop and restart.
`timescale 1ns/1ps
`default_nettype none
module ref_src_model #(
   parameter realtime HALF_A = 500.0,
   parameter realtime HALF_B = 750.0
) (
   // Run controls
   input  wire logic run_a,
   input  wire logic run_b,
   // Reference pins
   output var  logic clk_a,
   output var  logic clk_b
);
   initial clk_a = 1'b0;
   initial clk_b = 1'b0;
   // The second source is never faster than the first one.
   // A stopped source parks low, as its pull-down would leave it.
   always #(HALF_A) clk_a = run_a ? ~clk_a : 1'b0;
   always #(HALF_B) clk_b = run_b ? ~clk_b : 1'b0;
endmodule // ref_src_model
`default_nettype wire

// *** tb/ref_clk_checker.sv ***
// Assertion checker for the reference clock block.
`timescale 1ns/1ps
`default_nettype none
module ref_clk_checker #(
   parameter NPLL = 4,
   parameter NOUT = 6
) (
   // Clock and reset
   input wire logic               clk,
   input wire logic               rst,
   // Register port
   input wire logic [7:0]         addr,
   input wire logic [15:0]        wdata,
   input wire logic               wr,
   input wire logic               rd,
   input wire logic [15:0]        rdata,
   // Selection
   input wire logic               input_select_pin,
   input wire logic               ref_clk_out,
   input wire logic               on_secondary,
   input wire logic               primary_lost,
   // Settings
   input wire logic [NPLL-1:0]    pll_power_down,
   input wire logic [NPLL*7-1:0]  pll_pre_divide,
   input wire logic [NPLL*14-1:0] pll_feedback_m,
   input wire logic [NOUT*9-1:0]  out_ratio,
   input wire logic [NOUT-1:0]    out_enable,
   input wire logic [5:0]         crystal_load_cap,
   input wire logic [1:0]         crystal_drive_strength
);
   logic [2:0]  mode_q;
   logic [11:0] n0_q;
   logic [7:0]  hold_q;
   logic        sel_q;

   function automatic logic [8:0] ratio_of(input logic [7:0] s);
      if (s[6:0] == 7'h7F) return {8'h00, s[7]};
      return s[7] ? ({2'b00, s[6:0]} + 9'h002) << 1 : 9'h002;
   endfunction

   function automatic logic [NOUT-1:0] en_of(input logic [NOUT*9-1:0] r);
      for (int b = 0; b < NOUT; b++) en_of[b] = (r[b*9+:9] != 9'h000);
   endfunction

   // Hold counts cycles of a steady select pin in manual mode.
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= 3'h0;
         n0_q <= 12'h005;
         hold_q <= 8'h00;
         sel_q <= 1'b0;
      end else begin
         if (wr && addr == 8'h00) mode_q <= wdata[2:0];
         if (wr && addr == 8'h14) n0_q <= wdata[11:0];
         sel_q <= input_select_pin;
         if (mode_q[2] || sel_q != input_select_pin) hold_q <= 8'h00;
         else if (hold_q != 8'hFF) hold_q <= hold_q + 8'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_rd_idle; !rd |=> rdata == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_pd;
      !$past(rst) |-> pll_power_down == {1'b0, pll_pre_divide[20:14] == 7'h00,
         pll_pre_divide[13:7] == 7'h00, pll_pre_divide[6:0] == 7'h00};
   endproperty
   a_pd: assert property (p_pd) else $error("power down mismatch");
   property p_m0;
      wr && addr == 8'h18 |-> ##2 pll_feedback_m[13:0] == ($past(wdata[3:0], 2) == 4'h0 ?
         {1'b0, n0_q, 1'b0} : {1'b0, n0_q, 1'b0} + $past(wdata[3:0], 2) + 14'h0001);
   endproperty
   a_m0: assert property (p_m0) else $error("feedback value wrong");
   property p_crystal_load_trim;
      wr && addr == 8'h01 |-> ##2 crystal_load_cap == 6'h1C + $past(wdata[4:0], 2)
         && crystal_drive_strength == $past(wdata[9:8], 2);
   endproperty
   a_crystal_load_trim: assert property (p_crystal_load_trim) else $error("load trim wrong");
   property p_ratio;
      wr && addr >= 8'h21 && addr <= 8'h26 |-> ##2
         out_ratio[($past(addr, 2) - 8'h21) * 9 +: 9] == ratio_of($past(wdata[7:0], 2));
   endproperty
   a_ratio: assert property (p_ratio) else $error("divider decode wrong");
   property p_en; out_enable == en_of(out_ratio); endproperty
   a_en: assert property (p_en) else $error("enable and ratio disagree");
   property p_manual;
      !mode_q[2] && hold_q == 8'h64 |-> on_secondary == input_select_pin;
   endproperty
   a_manual: assert property (p_manual) else $error("manual select ignored");
   property p_glitch; $changed(on_secondary) |-> !ref_clk_out && !$past(ref_clk_out); endproperty
   a_glitch: assert property (p_glitch) else $error("switch while high");
   property p_auto;
      $rose(primary_lost) && mode_q[2] |-> ##[1:60] (on_secondary || !primary_lost);
   endproperty
   a_auto: assert property (p_auto) else $error("no switch to secondary");
   property p_revert;
      mode_q[2] && on_secondary && !primary_lost |-> ##[1:80] !on_secondary;
   endproperty
   a_revert: assert property (p_revert) else $error("no return to primary");

   c_lost: cover property (mode_q[2] && primary_lost && on_secondary);
   c_manual: cover property (!mode_q[2] && on_secondary);
   c_off: cover property (out_enable != {NOUT{1'b1}});
endmodule // ref_clk_checker

bind ref_clock_select_and_dividers ref_clk_checker #(.NPLL(NPLL), .NOUT(NOUT)) u_ref_clk_checker (
   .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .input_select_pin, .ref_clk_out,
   .on_secondary, .primary_lost, .pll_power_down, .pll_pre_divide, .pll_feedback_m,
   .out_ratio, .out_enable, .crystal_load_cap, .crystal_drive_strength
);
`default_nettype wire

// *** tb/ref_clock_select_and_dividers_tb_top.sv ***
// Self-checking bench for the reference clock block.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_select_and_dividers_tb_top;
   logic        clk = 1'b0;
   logic        rst, wr, rd, xin, alt, sel_pin, run_a, run_b;
   logic        ref_clk_out, on_secondary, primary_lost;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata;
   logic [3:0]  pll_power_down;
   logic [27:0] pll_pre_divide;
   logic [55:0] pll_feedback_m;
   logic [53:0] out_ratio;
   logic [5:0]  out_enable, crystal_load_cap;
   logic [11:0] out_idle_level;
   logic [1:0]  crystal_drive_strength;
   int          n_fail = 0;
   int          check_count = 0;

   always #25 clk = ~clk;

   ref_src_model u_ref_src_model (.run_a, .run_b, .clk_a(xin), .clk_b(alt));

   ref_clock_select_and_dividers u_ref_clock_select_and_dividers (
      .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .crystal_ref_input(xin),
      .alt_clock_input(alt), .input_select_pin(sel_pin), .ref_clk_out, .on_secondary,
      .primary_lost, .pll_power_down, .pll_pre_divide, .pll_feedback_m, .out_ratio,
      .out_enable, .out_idle_level, .crystal_load_cap, .crystal_drive_strength
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] ex);
      check_count++;
      if (got !== ex) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, ex);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rreg(input logic [7:0] a, output logic [15:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask

   task automatic wait_sec(input logic v);
      int i;
      for (i = 0; i < 400 && on_secondary !== v; i++) @(posedge clk);
      chk(on_secondary, v);
   endtask

   // Counts changes of the selected reference over 100 cycles.
   task automatic tog(output int n);
      logic p;
      n = 0;
      p = ref_clk_out;
      repeat (100) begin
         @(posedge clk);
         if (ref_clk_out !== p) n++;
         p = ref_clk_out;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(pll_pre_divide[27:21], 7'h03);
      chk(pll_pre_divide[6:0], 7'h01);
      chk(pll_power_down, 4'h0);
      chk(pll_feedback_m[13:0], 14'h000A);
      chk(pll_feedback_m[27:14], 14'h0005);
      chk(crystal_drive_strength, 2'h3);
   endtask

   task automatic t_pll;
      logic [15:0] d;
      wreg(8'h10, 16'h0000);
      wreg(8'h11, 16'h007F);
      wreg(8'h14, 16'h0007);
      wreg(8'h18, 16'h0003);
      wreg(8'h15, 16'h0FFF);
      // Derived outputs follow one edge after the register write.
      @(posedge clk);
      chk(pll_power_down, 4'h1);
      chk(pll_pre_divide[13:7], 7'h7F);
      chk(pll_feedback_m[13:0], 14'h0012);
      chk(pll_feedback_m[27:14], 14'h0FFF);
      wreg(8'h18, 16'h0000);
      wreg(8'h10, 16'h0001);
      @(posedge clk);
      chk(pll_feedback_m[13:0], 14'h000E);
      chk(pll_power_down, 4'h0);
      rreg(8'h30, d);
      chk(d, 16'h000E);
   endtask

   task automatic t_out;
      logic [15:0] set [6] = '{16'h027F, 16'h00FF, 16'h0100, 16'h0080, 16'h03FE, 16'h0085};
      logic [8:0]  ex [6] = '{9'h000, 9'h001, 9'h002, 9'h004, 9'h100, 9'h00E};
      logic [15:0] d;
      for (int b = 0; b < 6; b++) wreg(8'h21 + b[7:0], set[b]);
      for (int b = 0; b < 6; b++) begin
         chk(out_ratio[b*9+:9], ex[b]);
         chk(out_enable[b], ex[b] != 9'h000);
         chk(out_idle_level[b*2+:2], set[b][9:8]);
         rreg(8'h41 + b[7:0], d);
         chk(d, ex[b]);
      end
   endtask

   task automatic t_regs;
      logic [15:0] d;
      wreg(8'h01, 16'h011F);
      @(posedge clk);
      chk(crystal_load_cap, 6'h3B);
      wreg(8'h01, 16'h0300);
      @(posedge clk);
      chk(crystal_load_cap, 6'h1C);
      chk(crystal_drive_strength, 2'h3);
      wreg(8'h02, 16'hFFFF);
      rreg(8'h02, d);
      chk(d, 16'h0004);
      rreg(8'h7F, d);
      chk(d, 16'h0000);
   endtask

   task automatic t_manual;
      int n;
      run_a <= 1'b0;
      sel_pin <= 1'b1;
      wait_sec(1'b1);
      tog(n);
      chk(n != 0, 1'b1);
      sel_pin <= 1'b0;
      wait_sec(1'b0);
      tog(n);
      chk(n != 0, 1'b0);
      wreg(8'h00, 16'h0001);
      tog(n);
      chk(n != 0, 1'b1);
      chk(on_secondary, 1'b0);
      wreg(8'h00, 16'h0000);
      run_a <= 1'b1;
   endtask

   task automatic t_auto;
      logic [15:0] d;
      wreg(8'h00, 16'h0004);
      repeat (100) @(posedge clk);
      chk(on_secondary, 1'b0);
      run_a <= 1'b0;
      wait_sec(1'b1);
      chk(primary_lost, 1'b1);
      rreg(8'h02, d);
      chk(d, 16'h0003);
      run_a <= 1'b1;
      wait_sec(1'b0);
      chk(primary_lost, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      sel_pin = 1'b0;
      run_a = 1'b1;
      run_b = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset;
      t_pll;
      t_out;
      t_regs;
      t_manual;
      t_auto;
      end_sim;
   end

   initial begin
      #1_000_000;
      n_fail++;
      end_sim;
   end
endmodule // ref_clock_select_and_dividers_tb_top
`default_nettype wire
